// file: verilog/ict_regs.svh
// timing constants for the instruction cycle timing block
`ifndef ICT_REGS_SVH
`define ICT_REGS_SVH
`define ICT_CLK_MHZ        250
`define ICT_LOCAL_SETS     4
`define ICT_FLUSH_CLKS     24
`define ICT_CALL_CLKS      9
`define ICT_RET_CLKS       7
`define ICT_MUL_TYP        18
`define ICT_DIV_CLKS       37
`define ICT_EMUL_CLKS      24
`define ICT_EDIV_CLKS      40
`define ICT_EXTRACT_CLKS   7
`define ICT_MODIFY_CLKS    8
`define ICT_SCAN_BEST      8
`define ICT_SCAN_NORM      11
`define ICT_SCAN_WORST     14
`define ICT_BUS_QDEPTH     3
`define ICT_FP_REGS        4
`define ICT_FP_WIDTH       80
`endif

// file: verilog/ict_pkg.sv
// types for the instruction cycle timing block
`default_nettype none
package ict_pkg;
  typedef enum logic [4:0] {
    ICT_OP_LOGIC    = 5'b00000, // logical, rotate, logical shift
    ICT_OP_NOT      = 5'b00001,
    ICT_OP_ASHIFT   = 5'b00010, // arithmetic shifts, divide-style shift
    ICT_OP_BIT      = 5'b00011,
    ICT_OP_EXTRACT  = 5'b00100,
    ICT_OP_MODIFY   = 5'b00101,
    ICT_OP_SCAN     = 5'b00110,
    ICT_OP_MOVE     = 5'b00111,
    ICT_OP_ADDSUB   = 5'b01000,
    ICT_OP_CMPINC   = 5'b01001,
    ICT_OP_CARRY    = 5'b01010,
    ICT_OP_MUL      = 5'b01011,
    ICT_OP_DIV      = 5'b01100,
    ICT_OP_EMUL     = 5'b01101,
    ICT_OP_EDIV     = 5'b01110,
    ICT_OP_BR       = 5'b01111,
    ICT_OP_BR_CC    = 5'b10000, // branch-if and fault-if
    ICT_OP_BR_TEST  = 5'b10001,
    ICT_OP_BR_REG   = 5'b10010,
    ICT_OP_BR_LINK  = 5'b10011,
    ICT_OP_BR_CMP   = 5'b10100,
    ICT_OP_CALL     = 5'b10101,
    ICT_OP_RET      = 5'b10110,
    ICT_OP_MEM      = 5'b10111
  } ict_op_t;
  typedef enum logic [1:0] {
    ICT_ST_IDLE  = 2'b00,
    ICT_ST_BUSY  = 2'b01,
    ICT_ST_MEMW  = 2'b10
  } ict_state_t;
endpackage
`default_nettype wire

// file: verilog/ict_timing.sv
// execution timing sequencer: holds the decoder for each instruction's modelled time
`default_nettype none
`include "ict_regs.svh"
module ict_timing
  import ict_pkg::*;
#(
  parameter int FP_REGS  = `ICT_FP_REGS,
  parameter int FP_WIDTH = `ICT_FP_WIDTH,
  parameter int SETS     = `ICT_LOCAL_SETS,
  parameter int QDEPTH   = `ICT_BUS_QDEPTH
)(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                issue_valid,
  input  wire logic [4:0]          issue_op,
  input  wire logic                src1_literal,
  input  wire logic                src2_literal,
  input  wire logic                src2_is_last_dst,
  input  wire logic                sets_condition_code,
  input  wire logic [1:0]          variant,
  input  wire logic                branch_taken,
  input  wire logic                branch_overlap,
  input  wire logic [5:0]          src1_sig_bits,
  input  wire logic                bus_req_done,
  input  wire logic                fp_wr_en,
  input  wire logic [1:0]          fp_wr_idx,
  input  wire logic [FP_WIDTH-1:0] fp_wr_data,
  input  wire logic [1:0]          fp_rd_idx,
  output logic                     issue_ready,
  output logic                     instr_start,
  output logic [5:0]               exec_clocks_ff,
  output logic [FP_WIDTH-1:0]      fp_rd_data_ff,
  output logic [2:0]               sets_used_ff,
  output logic [1:0]               bus_outstanding_ff
);

  localparam logic [5:0] FLUSH = 6'(`ICT_FLUSH_CLKS);

  ict_state_t           state_ff;
  logic [5:0]           remain_ff;
  logic                 cc_fresh_ff;       // previous instruction set the condition code
  logic [5:0]           spill_ff;          // frames parked on the memory stack
  logic [FP_WIDTH-1:0]  fp_regs_ff [FP_REGS];
  logic [5:0]           nxt_clocks;
  logic                 bypass_hit;
  logic                 accept;
  logic                 bus_full;
  logic                 mem_issue;
  ict_op_t              op;

  assign op         = ict_op_t'(issue_op);
  assign bypass_hit = src1_literal | src2_literal | src2_is_last_dst;
  assign bus_full   = (bus_outstanding_ff == 2'(QDEPTH)) && !bus_req_done;
  // a memory request with a full queue waits in idle; in idle nothing else is refused
  assign issue_ready = (state_ff == ICT_ST_IDLE) && !(op == ICT_OP_MEM && bus_full);
  assign accept      = issue_valid && issue_ready;
  assign instr_start = accept;
  assign mem_issue   = accept && (op == ICT_OP_MEM);

  // multiply early-out table, interpolated between the listed points
  // the product needs eight bits: at 31 bits it reaches 230 before the divide
  function automatic logic [5:0] mul_clocks(input logic [5:0] bits);
    logic [9:0] span;
    logic [5:0] r;
    span = 10'd0;
    r    = 6'd21;
    if (bits <= 6'd2)
      r = 6'd9;
    else if (bits <= 6'd4)
      r = 6'd10;
    else if (bits <= 6'd8)
      r = 6'd11;
    else if (bits < 6'd32)
    begin
      // straight line from 11 clocks at 8 bits to 21 clocks at 32 bits
      span = {4'd0, bits - 6'd8} * 10'd10 / 10'd24;
      r    = 6'd11 + span[5:0];
    end
    return r;
  endfunction

  // decode the modelled execution time of the offered instruction
  always_comb
  begin
    nxt_clocks = 6'd1;
    unique case (op)
      ICT_OP_LOGIC:
      begin
        // one clock on a bypass hit, one more to fetch the second operand
        if (bypass_hit)
          nxt_clocks = 6'd1;
        else
          nxt_clocks = 6'd2;
      end
      ICT_OP_NOT:     nxt_clocks = 6'd1;
      ICT_OP_ASHIFT:
      begin
        // arithmetic shifts cost one clock more than the plain logic ops
        if (bypass_hit)
          nxt_clocks = 6'd2;
        else
          nxt_clocks = 6'd3;
      end
      ICT_OP_BIT:
      begin
        // single-bit operations share the shift timing
        if (bypass_hit)
          nxt_clocks = 6'd2;
        else
          nxt_clocks = 6'd3;
      end
      ICT_OP_EXTRACT: nxt_clocks = 6'(`ICT_EXTRACT_CLKS);
      ICT_OP_MODIFY:  nxt_clocks = 6'(`ICT_MODIFY_CLKS);
      ICT_OP_SCAN:
      begin
        // variant 0 best, 1 normal, 2/3 worst
        unique case (variant)
          2'd0:    nxt_clocks = 6'(`ICT_SCAN_BEST);
          2'd1:    nxt_clocks = 6'(`ICT_SCAN_NORM);
          default: nxt_clocks = 6'(`ICT_SCAN_WORST);
        endcase
        if (!cc_fresh_ff)
          nxt_clocks = nxt_clocks - 6'd1;
      end
      ICT_OP_MOVE:    nxt_clocks = 6'({1'b0, variant}) + 6'd1;
      ICT_OP_ADDSUB:
      begin
        // add, subtract and compare follow the bypass like the logic ops
        if (bypass_hit)
          nxt_clocks = 6'd1;
        else
          nxt_clocks = 6'd2;
      end
      ICT_OP_CMPINC:
      begin
        // the increment or decrement after the compare adds one clock
        if (bypass_hit)
          nxt_clocks = 6'd2;
        else
          nxt_clocks = 6'd3;
      end
      ICT_OP_CARRY:
      begin
        // waits one clock while a condition code set just before settles
        if (cc_fresh_ff)
          nxt_clocks = 6'd2;
        else
          nxt_clocks = 6'd1;
      end
      ICT_OP_MUL:
      begin
        // an unknown operand width falls back to the typical figure
        if (src1_sig_bits == 6'd0)
          nxt_clocks = 6'(`ICT_MUL_TYP);
        else
          nxt_clocks = mul_clocks(src1_sig_bits);
      end
      ICT_OP_DIV:     nxt_clocks = 6'(`ICT_DIV_CLKS);
      ICT_OP_EMUL:    nxt_clocks = 6'(`ICT_EMUL_CLKS);
      ICT_OP_EDIV:    nxt_clocks = 6'(`ICT_EDIV_CLKS);
      // branches: decoder-only; overlap hides the time down to zero, except 2 for branch-and-link and 3 for compare-and-branch
      ICT_OP_BR:      nxt_clocks = branch_overlap ? 6'd0 : 6'd2;
      ICT_OP_BR_REG:  nxt_clocks = branch_overlap ? 6'd0 : 6'd6;
      ICT_OP_BR_LINK: nxt_clocks = branch_overlap ? 6'd2 : 6'd8;
      ICT_OP_BR_CMP:  nxt_clocks = branch_overlap ? 6'd3
                                   : (branch_taken ? 6'd5 : 6'd4);
      ICT_OP_BR_CC, ICT_OP_BR_TEST:
      begin
        // worst case: 2 taken, one less untaken, one more after fresh setter
        nxt_clocks = branch_taken ? 6'd2 : 6'd1;
        if (cc_fresh_ff)
          nxt_clocks = nxt_clocks + 6'd1;
        if (op == ICT_OP_BR_TEST)
          nxt_clocks = nxt_clocks + 6'd1;
        if (branch_overlap)
          nxt_clocks = 6'd0;
      end
      ICT_OP_CALL:
      begin
        // a call with every set in use first spills the oldest frame
        nxt_clocks = 6'(`ICT_CALL_CLKS);
        if (sets_used_ff == 3'(SETS))
          nxt_clocks = nxt_clocks + FLUSH;
      end
      ICT_OP_RET:
      begin
        // reload only when the last resident frame returns to a spilled one
        nxt_clocks = 6'(`ICT_RET_CLKS);
        if (sets_used_ff == 3'd1 && spill_ff != 6'd0)
          nxt_clocks = nxt_clocks + FLUSH;
      end
      ICT_OP_MEM:     nxt_clocks = 6'd1;
      default:        nxt_clocks = 6'd1;  // unknown codes take one clock
    endcase
  end

  // sequencer: stall the decoder while the modelled time runs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff       <= ICT_ST_IDLE;
      remain_ff      <= 6'd0;
      exec_clocks_ff <= 6'd0;
    end
    else
    begin
      unique case (state_ff)
        ICT_ST_IDLE:
          if (accept)
          begin
            exec_clocks_ff <= nxt_clocks;
            // zero and one clock instructions leave the decoder free next cycle
            if (nxt_clocks > 6'd1)
            begin
              remain_ff <= nxt_clocks - 6'd1;
              state_ff  <= (op == ICT_OP_MEM) ? ICT_ST_MEMW : ICT_ST_BUSY;
            end
          end
        ICT_ST_BUSY, ICT_ST_MEMW:
        begin
          remain_ff <= remain_ff - 6'd1;
          if (remain_ff == 6'd1)
            state_ff <= ICT_ST_IDLE;
        end
        default: state_ff <= ICT_ST_IDLE;
      endcase
    end
  end

  // condition code scoreboard: tracks whether the last issued op set it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cc_fresh_ff <= 1'b0;
    else if (accept)
      cc_fresh_ff <= sets_condition_code;
  end

  // local register set allocation: resident sets plus a count of spilled frames
  // limitation: more than 63 spilled frames wrap the count and lose reloads
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sets_used_ff <= 3'd1;
      spill_ff     <= 6'd0;
    end
    else if (accept && op == ICT_OP_CALL)
    begin
      // the oldest frame leaves for the stack, the new one takes its set
      if (sets_used_ff == 3'(SETS))
        spill_ff <= spill_ff + 6'd1;
      else
        sets_used_ff <= sets_used_ff + 3'd1;
    end
    else if (accept && op == ICT_OP_RET)
    begin
      // resident frames are released first; the last one pulls a frame back
      if (sets_used_ff != 3'd1)
        sets_used_ff <= sets_used_ff - 3'd1;
      else if (spill_ff != 6'd0)
        spill_ff <= spill_ff - 6'd1;
    end
  end

  // bus request queue occupancy; issue and completion in one cycle cancel
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_outstanding_ff <= 2'd0;
    else
    begin
      // a stray completion on an empty queue is ignored rather than wrapping
      unique case ({mem_issue, bus_req_done})
        2'b10:
        begin
          bus_outstanding_ff <= bus_outstanding_ff + 2'd1;
        end
        2'b01:
        begin
          if (bus_outstanding_ff != 2'd0)
            bus_outstanding_ff <= bus_outstanding_ff - 2'd1;
        end
        2'b00, 2'b11:
        begin
          bus_outstanding_ff <= bus_outstanding_ff;
        end
      endcase
    end
  end

  // floating point register file, extended precision
  always_ff @(posedge clk)
  begin
    if (fp_wr_en)
      fp_regs_ff[fp_wr_idx] <= fp_wr_data;
  end

  // registered read port
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fp_rd_data_ff <= '0;
    else
      fp_rd_data_ff <= fp_regs_ff[fp_rd_idx];
  end

endmodule
`default_nettype wire

// file: testbench/ict_timing_asserts.sv
// checker for the instruction timing block ports
`default_nettype none
module ict_timing_asserts
  import ict_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       issue_valid,
  input wire logic [4:0] issue_op,
  input wire logic       src1_literal,
  input wire logic       src2_literal,
  input wire logic       src2_is_last_dst,
  input wire logic [5:0] src1_sig_bits,
  input wire logic       bus_req_done,
  input wire logic       issue_ready,
  input wire logic       instr_start,
  input wire logic [5:0] exec_clocks_ff,
  input wire logic [2:0] sets_used_ff,
  input wire logic [1:0] bus_outstanding_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a miss means the second operand comes from the register file
  wire miss = !src1_literal && !src2_literal && !src2_is_last_dst;
  property p_start; instr_start == (issue_valid && issue_ready); endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_add; instr_start && issue_op == ICT_OP_ADDSUB && miss
    |=> exec_clocks_ff == 6'h02 && !issue_ready ##1 issue_ready; endproperty
  a_add: assert property (p_add) else $error("add miss timing wrong");
  property p_hit; instr_start && issue_op == ICT_OP_LOGIC && src1_literal
    |=> exec_clocks_ff == 6'h01; endproperty
  a_hit: assert property (p_hit) else $error("bypass hit timing wrong");
  property p_not; instr_start && issue_op == ICT_OP_NOT |=> exec_clocks_ff == 6'h01; endproperty
  a_not: assert property (p_not) else $error("invert timing wrong");
  property p_ext; instr_start && issue_op == ICT_OP_EXTRACT
    |=> (!issue_ready && exec_clocks_ff == 6'h07) [*6] ##1 issue_ready; endproperty
  a_ext: assert property (p_ext) else $error("extract timing wrong");
  property p_div; instr_start && issue_op == ICT_OP_DIV |=> exec_clocks_ff == 6'h25; endproperty
  a_div: assert property (p_div) else $error("divide timing wrong");
  property p_mul; instr_start && issue_op == ICT_OP_MUL && src1_sig_bits == 6'h02
    |=> exec_clocks_ff == 6'h09; endproperty
  a_mul: assert property (p_mul) else $error("early out timing wrong");
  property p_full; bus_outstanding_ff == 2'h3 && issue_op == ICT_OP_MEM && !bus_req_done
    |-> !issue_ready; endproperty
  a_full: assert property (p_full) else $error("full queue not stalling");
  property p_call; instr_start && issue_op == ICT_OP_CALL && sets_used_ff != 3'h4
    |=> sets_used_ff == $past(sets_used_ff) + 3'h1; endproperty
  a_call: assert property (p_call) else $error("call set count wrong");
  c_call: cover property (instr_start && issue_op == ICT_OP_CALL && sets_used_ff == 3'h4);
  c_mul: cover property (instr_start && issue_op == ICT_OP_MUL);
  c_full: cover property (bus_outstanding_ff == 2'h3 && issue_valid);
endmodule
bind ict_timing ict_timing_asserts chk (.*);
`default_nettype wire

// file: testbench/ict_bus_model.sv
// bus control stand-in: retires queued memory requests, stalls on hold
`default_nettype none
module ict_bus_model
  import ict_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       instr_start,
  input  wire logic [4:0] issue_op,
  input  wire logic       hold,
  output logic            bus_req_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pend_ff;
  // at most one retire every other clock, so a burst really fills the queue
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_ff      <= 2'h0;
      bus_req_done <= 1'b0;
    end
    else
    begin
      pend_ff <= pend_ff + 2'(instr_start && issue_op == ICT_OP_MEM) - 2'(bus_req_done);
      bus_req_done <= !bus_req_done && !hold && pend_ff != 2'h0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/ict_timing_tb.sv
// self-checking bench for the instruction timing block
`default_nettype none
module ict_timing_tb
  import ict_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        sys_rst, issue_valid, src1_literal, src2_literal, src2_is_last_dst, hold;
  logic        sets_condition_code, branch_taken, branch_overlap, fp_wr_en;
  logic        issue_ready, instr_start, bus_req_done;
  logic [4:0]  issue_op;
  logic [1:0]  variant, fp_wr_idx, fp_rd_idx, bus_outstanding_ff;
  logic [5:0]  src1_sig_bits, exec_clocks_ff;
  logic [2:0]  sets_used_ff;
  logic [79:0] fp_wr_data, fp_rd_data_ff;
  int          fails = 0;
  int          checks = 0;
  always #2 clk = ~clk;
  ict_timing dut (.*);
  ict_bus_model bus (.*);
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // issue one instruction; e of zero skips the timing comparison
  task automatic run(input logic [4:0] o, input logic [5:0] e, input logic [5:0] f = 6'h00,
                     input logic [1:0] v = 2'h0, input logic [5:0] b = 6'h00);
    int n;
    issue_op = o;
    {branch_overlap, branch_taken, sets_condition_code, src2_literal, src2_is_last_dst,
     src1_literal} = f;
    variant = v;
    src1_sig_bits = b;
    issue_valid = 1'b1;
    n = 0;
    #1;
    while (issue_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    issue_valid = 1'b0;
    // n counts clocks from this start to the next possible start
    for (n = 1; issue_ready !== 1'b1 && n < 64; n++)
      @(negedge clk);
    if (e != 6'h00)
    begin
      chk("exec", 80'(e), 80'(exec_clocks_ff));
      chk("gap", 80'(e), 80'(n));
    end
  endtask
  task automatic t_reset;
    chk("exec", 80'h0, 80'(exec_clocks_ff));
    chk("sets", 80'h1, 80'(sets_used_ff));
    chk("queue", 80'h0, 80'(bus_outstanding_ff));
    $display("reset done");
  endtask
  task automatic t_alu;
    run(ICT_OP_LOGIC, 6'h01, 6'h01);
    run(ICT_OP_NOT, 6'h01);
    run(ICT_OP_ASHIFT, 6'h03);
    run(ICT_OP_BIT, 6'h02, 6'h02);
    run(ICT_OP_EXTRACT, 6'h07);
    run(ICT_OP_MODIFY, 6'h08, 6'h04);
    run(ICT_OP_ADDSUB, 6'h02);
    run(ICT_OP_CMPINC, 6'h02, 6'h04);
    for (int i = 0; i < 4; i++)
      run(ICT_OP_MOVE, 6'(i + 1), 6'h00, 2'(i));
    $display("alu done");
  endtask
  task automatic t_cc;
    run(ICT_OP_ADDSUB, 6'h01, 6'h09);
    run(ICT_OP_CARRY, 6'h02);
    run(ICT_OP_CARRY, 6'h01);
    run(ICT_OP_ADDSUB, 6'h01, 6'h09);
    run(ICT_OP_SCAN, 6'h08);
    run(ICT_OP_SCAN, 6'h0a, 6'h00, 2'h1);
    run(ICT_OP_SCAN, 6'h0d, 6'h00, 2'h2);
    $display("condition code done");
  endtask
  task automatic t_mul;
    run(ICT_OP_MUL, 6'h09, 6'h00, 2'h0, 6'h02);
    run(ICT_OP_MUL, 6'h0b, 6'h00, 2'h0, 6'h08);
    run(ICT_OP_MUL, 6'h15, 6'h00, 2'h0, 6'h20);
    run(ICT_OP_MUL, 6'h12);
    run(ICT_OP_DIV, 6'h25);
    run(ICT_OP_EMUL, 6'h18);
    run(ICT_OP_EDIV, 6'h28);
    $display("multiply done");
  endtask
  task automatic t_branch;
    run(ICT_OP_BR, 6'h02, 6'h10);
    run(ICT_OP_BR_REG, 6'h06, 6'h10);
    run(ICT_OP_BR_LINK, 6'h08, 6'h10);
    run(ICT_OP_BR_CMP, 6'h05, 6'h10);
    run(ICT_OP_BR_CMP, 6'h04);
    run(ICT_OP_BR_CMP, 6'h03, 6'h30);
    run(ICT_OP_BR_CC, 6'h01);
    run(ICT_OP_ADDSUB, 6'h01, 6'h09);
    run(ICT_OP_BR_CC, 6'h03, 6'h10);
    run(ICT_OP_ADDSUB, 6'h01, 6'h09);
    run(ICT_OP_NOT, 6'h01);
    run(ICT_OP_BR_TEST, 6'h03, 6'h10);
    $display("branch done");
  endtask
  task automatic t_call;
    for (int i = 2; i < 5; i++)
    begin
      run(ICT_OP_CALL, 6'h09);
      chk("sets", 80'(i), 80'(sets_used_ff));
    end
    run(ICT_OP_CALL, 6'h21);
    chk("sets", 80'h4, 80'(sets_used_ff));
    for (int i = 0; i < 3; i++)
      run(ICT_OP_RET, 6'h07);
    run(ICT_OP_RET, 6'h1f);
    $display("call done");
  endtask
  task automatic t_mem;
    hold = 1'b1;
    repeat (3) run(ICT_OP_MEM, 6'h00);
    issue_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk("ready", 80'h0, 80'(issue_ready));
    chk("queue", 80'h3, 80'(bus_outstanding_ff));
    hold = 1'b0;
    run(ICT_OP_MEM, 6'h00);
    for (int k = 0; k < 40 && bus_outstanding_ff !== 2'h0; k++)
      @(negedge clk);
    chk("queue", 80'h0, 80'(bus_outstanding_ff));
    $display("memory queue done");
  endtask
  task automatic t_fp;
    fp_wr_en = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      fp_wr_idx = 2'(i);
      fp_wr_data = {5{16'hc35a ^ 16'(i)}};
      @(negedge clk);
    end
    fp_wr_en = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      fp_rd_idx = 2'(i);
      @(negedge clk);
      chk("fp", {5{16'hc35a ^ 16'(i)}}, fp_rd_data_ff);
    end
    $display("fp registers done");
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {sys_rst, issue_valid, src1_literal, src2_literal, src2_is_last_dst, hold} = 6'h20;
    {sets_condition_code, branch_taken, branch_overlap, fp_wr_en} = 4'h0;
    {issue_op, variant, src1_sig_bits, fp_wr_idx, fp_rd_idx} = 17'h0_0000;
    fp_wr_data = 80'h0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_call;
    t_alu;
    t_cc;
    t_mul;
    t_branch;
    t_mem;
    t_fp;
    test_done;
  end
  // tests need about four hundred clocks; far beyond that means a hang
  initial
  begin
    #80000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
